// ===== tb/asp_peer.sv
`timescale 1ns/1ps
module asp_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;
  // one frame, first bit first, then back to idle high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_line <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask : send
  // waits for the start edge, then samples each bit at its middle
  task automatic recv(input int n, output logic [11:0] bits);
    int w;
    bits = 12'h000;
    w = 0;
    while (i_line !== 1'b0 && w < 4000) begin
      @(posedge i_clk);
      w++;
    end
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_line;
      repeat (BIT_CLKS) @(posedge i_clk);
    end
  endtask : recv
endmodule : asp_peer

// ===== tb/asp_top_tb.sv
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ser_in, ser_out, sir_out, irq, dma_rx, dma_tx;
  logic [31:0] r, d;
  logic e;
  logic [11:0] got, exp;
  int n, fails = 0, comparisons = 0, highs;
  integer seed;

  always #12.5 clk = ~clk;

  asp_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ser_in(ser_in), .i_sir_in(sir_out),
    .o_ser_out(ser_out), .o_sir_out(sir_out), .o_irq(irq), .o_dma_rx_req(dma_rx),
    .o_dma_tx_req(dma_tx));

  asp_peer #(.BIT_CLKS(16)) peer (.i_clk(clk), .i_line(ser_out), .o_line(ser_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int w;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, wd, x, y);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h0, x, y);
    chk(x, want);
  endtask : rdchk

  // expected line bits, first bit sent in bit 0
  function automatic logic [11:0] frame(input logic [7:0] dd, input int wl, input int par,
                                        input bit s2, output int cnt);
    logic [7:0] m;
    m = dd & 8'((9'h1 << (wl + 5)) - 9'h1);
    frame = 12'h000;
    cnt = 1;
    for (int i = 0; i < wl + 5; i++) begin
      frame[cnt] = m[i];
      cnt++;
    end
    if (par != 0) begin
      frame[cnt] = (par == 1) ? ^m : (par == 2) ? ~^m : (par == 3);
      cnt++;
    end
    frame[cnt] = 1'b1;
    cnt++;
    if (s2) begin
      frame[cnt] = 1'b1;
      cnt++;
    end
  endfunction : frame

  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    seed = 32'hd21ba30e;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(`ASP_OFF_STAT, 32'h10);
    rdchk(`ASP_OFF_CTRL, 32'h0);
    rdchk(`ASP_OFF_IST, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(`ASP_OFF_BAUD, 32'h1);
    rdchk(`ASP_OFF_BAUD, 32'h1);
    for (int i = 0; i < 20; i++) begin
      d = $random(seed);
      wr(`ASP_OFF_CTRL, 32'h7 | ((i % 4) << 3) | (((i / 5) % 2) << 5) | ((i % 5) << 6));
      exp = frame(d[7:0], i % 4, i % 5, (i / 5) % 2, n);
      wr(`ASP_OFF_DATA, d);
      fork
        peer.recv(n, got);
        begin
          apb(1'b0, `ASP_OFF_STAT, 32'h0, r, e);
          chk({31'h0, r[0]}, 32'h1);
        end
      join
      chk({20'h0, got}, {20'h0, exp});
      repeat (16) @(posedge clk);
      rdchk(`ASP_OFF_STAT, 32'h10);
    end
    wr(`ASP_OFF_CTRL, 32'h5f);
    fork
      peer.recv(11, got);
      begin
        wr(`ASP_OFF_DATA, 32'ha5);
        wr(`ASP_OFF_DATA, 32'h3c);
        wr(`ASP_OFF_CTRL, 32'h5e);
        rdchk(`ASP_OFF_CTRL, 32'h58);
      end
    join
    chk({20'h0, got}, {20'h0, frame(8'ha5, 3, 1, 1'b0, n)});
    repeat (400) @(posedge clk);
    rdchk(`ASP_OFF_STAT, 32'h10);
    wr(`ASP_OFF_CTRL, 32'h25f);
    // line register follows the control write one edge later
    @(posedge clk);
    highs = 0;
    repeat (2 * 12 * 16) begin
      @(posedge clk);
      highs += ser_out;
    end
    chk(highs, 0);
    wr(`ASP_OFF_CTRL, 32'h5f);
    repeat (3) @(posedge clk);
    chk({31'h0, ser_out}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      exp = frame(d[7:0], 3, 1, 1'b0, n) ^ ((k == 3) ? 12'h200 : 12'h000);
      peer.send(exp, n);
      repeat (4) @(posedge clk);
      rdchk(`ASP_OFF_STAT, 32'h12);
      rdchk(`ASP_OFF_DATA, {20'h0, (k == 3) ? 4'h2 : 4'h0, d[7:0]});
    end
    peer.send(12'h000, 11);
    repeat (4) @(posedge clk);
    rdchk(`ASP_OFF_DATA, 32'h500);
    rdchk(`ASP_OFF_IST, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(`ASP_OFF_IMSK, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`ASP_OFF_IST, 32'hf);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(`ASP_OFF_IST, 32'h0);
    wr(`ASP_OFF_DMA, 32'h2);
    @(posedge clk);
    chk({30'h0, dma_rx, dma_tx}, 32'h1);
    wr(`ASP_OFF_DMA, 32'h5);
    d = $random(seed);
    peer.send(frame(d[7:0], 3, 1, 1'b0, n), n);
    repeat (4) @(posedge clk);
    chk({30'h0, dma_rx, dma_tx}, 32'h2);
    rdchk(`ASP_OFF_DATA, {24'h0, d[7:0]});
    peer.send(frame(d[7:0], 3, 1, 1'b0, n) ^ 12'h200, n);
    repeat (4) @(posedge clk);
    rdchk(`ASP_OFF_DMA, 32'h4);
    chk({31'h0, dma_rx}, 32'h0);
    rdchk(`ASP_OFF_DATA, {24'h2, d[7:0]});
    // infrared loopback: pulses out are decoded by the receiver
    wr(`ASP_OFF_CTRL, 32'h45f);
    d = $random(seed);
    wr(`ASP_OFF_DATA, d);
    repeat (12 * 16 + 40) @(posedge clk);
    rdchk(`ASP_OFF_DATA, {24'h0, d[7:0]});
    rdchk(`ASP_OFF_STAT, 32'h10);
    wr(`ASP_OFF_CTRL, 32'h5f);
    tally_and_finish();
  end
endmodule : asp_top_tb

// ===== verilog/asp_pkg.sv
package asp_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asp_rx_st_t;
endpackage : asp_pkg

// ===== verilog/asp_regs.svh
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
// register byte offsets
`define ASP_OFF_DATA 8'h00
`define ASP_OFF_STAT 8'h04
`define ASP_OFF_CTRL 8'h08
`define ASP_OFF_BAUD 8'h0c
`define ASP_OFF_IST 8'h10
`define ASP_OFF_IMSK 8'h14
`define ASP_OFF_DMA 8'h18
// control fields
`define ASP_CTL_PEN 0
`define ASP_CTL_TEN 1
`define ASP_CTL_REN 2
`define ASP_CTL_WLEN_LO 3
`define ASP_CTL_STOP2 5
`define ASP_CTL_PAR_LO 6
`define ASP_CTL_BRK 9
`define ASP_CTL_SIR 10
`define ASP_CTL_W 11
`define ASP_CTL_RST 11'h000
// parity codes
`define ASP_PAR_NONE 3'h0
`define ASP_PAR_EVEN 3'h1
`define ASP_PAR_ODD 3'h2
`define ASP_PAR_ONE 3'h3
`define ASP_PAR_ZERO 3'h4
// rx entry flags above the 8 data bits
`define ASP_RXE_FRM 8
`define ASP_RXE_PAR 9
`define ASP_RXE_BRK 10
`define ASP_RXE_OVR 11
// dma control bits
`define ASP_DMA_RXEN 0
`define ASP_DMA_TXEN 1
`define ASP_DMA_STOP 2
// interrupt width, baud reset and bit timing
`define ASP_IRQ_W 4
`define ASP_BAUD_RST 16'h0000
`define ASP_OVS_LAST 4'hf
`define ASP_HALF_BIT 4'h7
`define ASP_SIR_TICKS 4'h3
`endif

// ===== verilog/asp_top.sv
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_top import asp_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ser_in,
  input wire logic i_sir_in,
  output logic o_ser_out,
  output logic o_sir_out,
  output logic o_irq,
  output logic o_dma_rx_req,
  output logic o_dma_tx_req
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(FIFO_DEPTH);

  logic [`ASP_CTL_W-1:0] ctrl_reg, ctrl_next;
  logic [15:0] baud_reg, baud_next, bcnt_reg, bcnt_next;
  logic [`ASP_IRQ_W-1:0] ist_reg, ist_next, imsk_reg, imsk_next;
  logic [2:0] dma_reg, dma_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [11:0] rxq_reg [FIFO_DEPTH];
  logic [7:0] txq_reg [FIFO_DEPTH];
  logic [AW-1:0] txw_reg, txw_next, txr_reg, txr_next, rxw_reg, rxw_next, rxr_reg, rxr_next;
  logic [AW:0] txc_reg, txc_next, rxc_reg, rxc_next;
  asp_tx_st_t tx_st_reg, tx_st_next;
  asp_rx_st_t rx_st_reg, rx_st_next;
  logic [3:0] tx_tk_reg, tx_tk_next, rx_tk_reg, rx_tk_next, sir_reg, sir_next;
  logic [2:0] tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
  logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic tx_par_reg, tx_par_next, perr_reg, perr_next, rxz_reg, rxz_next;
  logic ovrp_reg, ovrp_next, ser_reg, ser_next, siro_reg, siro_next;
  logic acc, wr, rd, mapped, tick, pen, ten, ren, stop2, brk, sir, busy;
  logic [1:0] wlen;
  logic [2:0] pmode, last_bit;
  logic [7:0] dmask, rx_data;
  logic tx_push, tx_pop, tx_flush, rx_push, rx_pop, tx_line, rxl;
  logic ev_rx, ev_tx, ev_err, ev_ovr;
  logic [11:0] rx_entry;

  function automatic logic asp_par(input logic [2:0] m, input logic [7:0] d);
    unique case (m)
      `ASP_PAR_EVEN: return ^d;
      `ASP_PAR_ODD: return ~^d;
      `ASP_PAR_ONE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : asp_par

  assign pen = ctrl_reg[`ASP_CTL_PEN];
  assign ten = ctrl_reg[`ASP_CTL_TEN];
  assign ren = ctrl_reg[`ASP_CTL_REN];
  assign wlen = ctrl_reg[`ASP_CTL_WLEN_LO +: 2];
  assign stop2 = ctrl_reg[`ASP_CTL_STOP2];
  assign pmode = ctrl_reg[`ASP_CTL_PAR_LO +: 3];
  assign brk = ctrl_reg[`ASP_CTL_BRK];
  assign sir = ctrl_reg[`ASP_CTL_SIR];
  assign last_bit = {1'b1, wlen};
  assign dmask = 8'(8'hff >> (2'd3 - wlen));
  assign rx_data = 8'(rx_sh_reg >> (2'd3 - wlen));

  // apb slave, zero wait states
  assign acc = i_psel & i_penable;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign mapped = i_paddr inside {`ASP_OFF_DATA, `ASP_OFF_STAT, `ASP_OFF_CTRL,
                                  `ASP_OFF_BAUD, `ASP_OFF_IST, `ASP_OFF_IMSK, `ASP_OFF_DMA};
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata = prdata_reg;
  assign tick = (baud_reg != 16'h0000) && (bcnt_reg >= baud_reg - 16'h0001);
  assign busy = (tx_st_reg != TX_IDLE) || (txc_reg != '0);
  assign o_irq = |(ist_reg & imsk_reg);
  assign o_dma_rx_req = dma_reg[`ASP_DMA_RXEN] & (rxc_reg != '0);
  assign o_dma_tx_req = dma_reg[`ASP_DMA_TXEN] & (txc_reg != FULL);
  assign o_ser_out = ser_reg;
  assign o_sir_out = siro_reg;

  always_comb begin : reg_next
    ctrl_next = ctrl_reg;
    baud_next = baud_reg;
    imsk_next = imsk_reg;
    dma_next = dma_reg;
    prdata_next = prdata_reg;
    bcnt_next = tick ? 16'h0000 : bcnt_reg + 16'h0001;
    ist_next = ist_reg;
    if (wr && i_paddr == `ASP_OFF_CTRL) begin
      ctrl_next = i_pwdata[`ASP_CTL_W-1:0];
      if (!i_pwdata[`ASP_CTL_PEN]) begin
        ctrl_next[`ASP_CTL_TEN] = 1'b0;
        ctrl_next[`ASP_CTL_REN] = 1'b0;
      end
    end
    if (wr && i_paddr == `ASP_OFF_BAUD) baud_next = i_pwdata[15:0];
    if (wr && i_paddr == `ASP_OFF_IMSK) imsk_next = i_pwdata[`ASP_IRQ_W-1:0];
    if (wr && i_paddr == `ASP_OFF_DMA) dma_next = i_pwdata[2:0];
    if (ev_err && dma_reg[`ASP_DMA_STOP]) dma_next[`ASP_DMA_RXEN] = 1'b0;
    if (wr && i_paddr == `ASP_OFF_IST) ist_next = ist_reg & ~i_pwdata[`ASP_IRQ_W-1:0];
    ist_next = ist_next | {ev_ovr, ev_err, ev_tx, ev_rx};
    if (i_psel && !i_penable) begin
      unique case (i_paddr)
        `ASP_OFF_DATA: prdata_next = (rxc_reg != '0) ? {20'h00000, rxq_reg[rxr_reg]} : 32'h0;
        `ASP_OFF_STAT: prdata_next = {27'h0, txc_reg == '0, txc_reg == FULL,
                                      rxc_reg == FULL, rxc_reg != '0, busy};
        `ASP_OFF_CTRL: prdata_next = {21'h0, ctrl_reg};
        `ASP_OFF_BAUD: prdata_next = {16'h0000, baud_reg};
        `ASP_OFF_IST: prdata_next = {28'h0, ist_reg};
        `ASP_OFF_IMSK: prdata_next = {28'h0, imsk_reg};
        `ASP_OFF_DMA: prdata_next = {29'h0, dma_reg};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= `ASP_CTL_RST;
      baud_reg <= `ASP_BAUD_RST;
      bcnt_reg <= 16'h0000;
      imsk_reg <= '0;
      ist_reg <= '0;
      dma_reg <= 3'h0;
      prdata_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      baud_reg <= baud_next;
      bcnt_reg <= bcnt_next;
      imsk_reg <= imsk_next;
      ist_reg <= ist_next;
      dma_reg <= dma_next;
      prdata_reg <= prdata_next;
    end
  end

  // queues
  assign tx_push = wr && i_paddr == `ASP_OFF_DATA && txc_reg != FULL;
  assign rx_pop = rd && i_paddr == `ASP_OFF_DATA && rxc_reg != '0;
  assign tx_flush = tx_st_reg == TX_IDLE && !(pen && ten) && txc_reg != '0;

  always_comb begin : fifo_next
    txw_next = txw_reg + AW'(tx_push);
    txr_next = txr_reg + AW'(tx_pop);
    txc_next = txc_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    rxw_next = rxw_reg + AW'(rx_push);
    rxr_next = rxr_reg + AW'(rx_pop);
    rxc_next = rxc_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    if (tx_flush) begin
      txr_next = txw_reg;
      txw_next = txw_reg;
      txc_next = '0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {txw_reg, txr_reg, rxw_reg, rxr_reg} <= '0;
      txc_reg <= '0;
      rxc_reg <= '0;
    end else begin
      {txw_reg, txr_reg, rxw_reg, rxr_reg} <= {txw_next, txr_next, rxw_next, rxr_next};
      txc_reg <= txc_next;
      rxc_reg <= rxc_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (tx_push) txq_reg[txw_reg] <= i_pwdata[7:0];
    if (rx_push) rxq_reg[rxw_reg] <= rx_entry;
  end

  // transmitter
  always_comb begin : tx_next
    tx_st_next = tx_st_reg;
    tx_tk_next = tx_tk_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    tx_par_next = tx_par_reg;
    tx_pop = 1'b0;
    ev_tx = 1'b0;
    tx_line = 1'b1;
    if (tx_st_reg != TX_IDLE && tick) tx_tk_next = tx_tk_reg + 4'h1;
    unique case (tx_st_reg)
      TX_IDLE: begin
        if (tick && pen && ten && txc_reg != '0) begin
          tx_pop = 1'b1;
          tx_sh_next = txq_reg[txr_reg] & dmask;
          tx_par_next = asp_par(pmode, txq_reg[txr_reg] & dmask);
          tx_st_next = TX_START;
          tx_tk_next = 4'h0;
        end
      end
      TX_START: begin
        tx_line = 1'b0;
        if (tick && tx_tk_reg == `ASP_OVS_LAST) begin
          tx_st_next = TX_DATA;
          tx_bit_next = 3'h0;
        end
      end
      TX_DATA: begin
        tx_line = tx_sh_reg[0];
        if (tick && tx_tk_reg == `ASP_OVS_LAST) begin
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
          tx_bit_next = tx_bit_reg + 3'h1;
          if (tx_bit_reg == last_bit) begin
            tx_st_next = (pmode == `ASP_PAR_NONE) ? TX_STOP : TX_PAR;
            tx_bit_next = 3'h0;
          end
        end
      end
      TX_PAR: begin
        tx_line = tx_par_reg;
        if (tick && tx_tk_reg == `ASP_OVS_LAST) tx_st_next = TX_STOP;
      end
      TX_STOP: begin
        if (tick && tx_tk_reg == `ASP_OVS_LAST) begin
          if (stop2 && tx_bit_reg == 3'h0) begin
            tx_bit_next = 3'h1;
          end else begin
            tx_st_next = TX_IDLE;
            ev_tx = 1'b1;
          end
        end
      end
    endcase
    ser_next = tx_line && !brk;
    siro_next = sir && !ser_next && tx_tk_reg < `ASP_SIR_TICKS;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_st_reg <= TX_IDLE;
      tx_tk_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_par_reg <= 1'b0;
      ser_reg <= 1'b1;
      siro_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_tk_reg <= tx_tk_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      tx_par_reg <= tx_par_next;
      ser_reg <= ser_next;
      siro_reg <= siro_next;
    end
  end

  // receiver; infrared pulse stretched to one bit time
  assign rxl = sir ? (sir_reg == 4'h0) : i_ser_in;

  always_comb begin : rx_next
    rx_st_next = rx_st_reg;
    rx_tk_next = rx_tk_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    perr_next = perr_reg;
    rxz_next = rxz_reg;
    ovrp_next = ovrp_reg;
    sir_next = sir_reg;
    rx_push = 1'b0;
    ev_rx = 1'b0;
    ev_err = 1'b0;
    ev_ovr = 1'b0;
    rx_entry = {ovrp_reg, rxz_reg && !rxl, perr_reg, !rxl, rx_data};
    if (i_sir_in) sir_next = `ASP_OVS_LAST;
    else if (tick && sir_reg != 4'h0) sir_next = sir_reg - 4'h1;
    if (rx_st_reg != RX_IDLE && tick) rx_tk_next = rx_tk_reg + 4'h1;
    unique case (rx_st_reg)
      RX_IDLE: begin
        if (tick && pen && ren && !rxl) begin
          rx_st_next = RX_START;
          rx_tk_next = 4'h0;
        end
      end
      RX_START: begin
        if (tick && rx_tk_reg == `ASP_HALF_BIT) begin
          rx_st_next = rxl ? RX_IDLE : RX_DATA;
          rx_tk_next = 4'h0;
          rx_bit_next = 3'h0;
          rxz_next = 1'b1;
          perr_next = 1'b0;
        end
      end
      RX_DATA: begin
        if (tick && rx_tk_reg == `ASP_OVS_LAST) begin
          rx_sh_next = {rxl, rx_sh_reg[7:1]};
          rxz_next = rxz_reg && !rxl;
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == last_bit) rx_st_next = (pmode == `ASP_PAR_NONE) ? RX_STOP : RX_PAR;
        end
      end
      RX_PAR: begin
        if (tick && rx_tk_reg == `ASP_OVS_LAST) begin
          perr_next = rxl != asp_par(pmode, rx_data);
          rxz_next = rxz_reg && !rxl;
          rx_st_next = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick && rx_tk_reg == `ASP_OVS_LAST) begin
          ev_err = perr_reg || !rxl;
          rx_st_next = rxl ? RX_IDLE : RX_BRK;
          if (rxc_reg == FULL) begin
            ovrp_next = 1'b1;
            ev_ovr = 1'b1;
          end else begin
            rx_push = 1'b1;
            ev_rx = 1'b1;
            ovrp_next = 1'b0;
          end
        end
      end
      RX_BRK: begin
        if (rxl) rx_st_next = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_st_reg <= RX_IDLE;
      rx_tk_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      {perr_reg, rxz_reg, ovrp_reg} <= 3'h0;
      sir_reg <= 4'h0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_tk_reg <= rx_tk_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      {perr_reg, rxz_reg, ovrp_reg} <= {perr_next, rxz_next, ovrp_next};
      sir_reg <= sir_next;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  chk_break_line: assert property (brk |=> !o_ser_out) else $error("break not low");
  chk_start_low: assert property (tx_st_reg == TX_START && !brk |=> !o_ser_out)
    else $error("start bit not low");
  chk_stop_high: assert property (tx_st_reg == TX_STOP && !brk |=> o_ser_out)
    else $error("stop bit not high");
  chk_two_stop: assert property (tx_st_reg == TX_STOP && tick && tx_tk_reg == 4'hf && stop2
    && tx_bit_reg == 3'h0 |=> tx_st_reg == TX_STOP) else $error("second stop missing");
  chk_busy_end: assert property ($fell(busy) |-> tx_st_reg == TX_IDLE && txc_reg == '0)
    else $error("busy dropped early");
  chk_rx_avail: assert property (rx_push && !rx_pop |=> rxc_reg != '0)
    else $error("rx entry lost");
  chk_baud_gap: assert property (tick && baud_reg > 16'h0001 && !$changed(baud_reg) |=> !tick)
    else $error("baud tick too fast");
  chk_tx_flush: assert property (tx_flush && !tx_push |=> txc_reg == '0)
    else $error("tx queue not flushed");
  chk_ctl_clear: assert property (wr && i_paddr == `ASP_OFF_CTRL && !i_pwdata[0]
    |=> !ten && !ren) else $error("enables not cleared");
  chk_dma_stop: assert property (ev_err && dma_reg[2] |=> !dma_reg[0])
    else $error("rx dma not stopped");
  chk_fifo_bound: assert property (rxc_reg <= FULL && txc_reg <= FULL)
    else $error("queue count overflow");
  chk_sir_pulse: assert property (sir && !brk && tx_st_reg == TX_START && tx_tk_reg == 4'h0
    |=> o_sir_out) else $error("no infrared pulse");
  chk_mid_sample: assert property (rx_st_reg == RX_START && $past(rx_st_reg) == RX_IDLE
    |-> rx_tk_reg == 4'h0) else $error("start not aligned");
  cov_tx_done: cover property (ev_tx);
  cov_rx_char: cover property (ev_rx);
  cov_rx_break: cover property (rx_st_reg == RX_BRK);
  cov_overrun: cover property (ev_ovr);
endmodule : asp_top
